// ==== hw/mrom_host.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - Host drives the address high byte on the muxed lines while the strobe is active.
// RULE2 - Device latches the high byte on the strobe's trailing edge for the access.
// RULE3 - Only three latched high bits feed the device's region decode.
// RULE4 - After the strobe ends the host puts the low address byte on the lines.
// RULE5 - Device drives its eight data lines only in an enabled read, else floats.
// RULE6 - Chip selects choose the device; read enable opens its data outputs.
// RULE7 - Each chip-select active level is a per-device mask constant.
// RULE8 - Chain output is high when selected or chain input high, else low.
// RULE9 - Chained outputs link device to device; the last disables RAM.
// RULE10 - Select sense and address region are per-device mask constants.
// RULE11 - Inside any ROM region the ROM answers and RAM is disabled.
// RULE12 - Latched high bits are compared with a mask value: one 4096-byte area in each 32768-byte half of the address space.
// RULE13 - Data is driven only when both selects, read and region match agree.
// RULE14 - Word index uses latched high bits plus the live low byte.
module mrom_host
	import mrom_pkg::*;
#(
	parameter bit CS1_ACTIVE_HIGH = 1'b1,
	parameter bit CS2_ACTIVE_HIGH = 1'b1
)
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	input  wire logic              req_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	output logic                   busy_o,
	output logic                   rsp_valid_o,
	output logic [BYTE_W-1:0]      rsp_data_o,
	output logic                   rsp_rom_o,
	output logic [BYTE_W-1:0]      muxed_address_lines_o,
	output logic                   address_latch_strobe_o,
	output logic                   memory_read_enable_o,
	output logic                   cs1_o,
	output logic                   cs2_o,
	input  wire logic [BYTE_W-1:0] data_bus_i,
	output logic [BYTE_W-1:0]      data_bus_o,
	output logic                   data_bus_oe_o,
	input  wire logic              chain_enable_output_i
);
	mrom_sync_if sy ();

	mrom_state_e      state_q;
	logic [CNT_W-1:0] cnt_q;
	logic [ADDR_W-1:0] addr_q;

	mrom_sync u_sync (
		.ref_clk_i   (ref_clk_i),
		.rst_b_i     (rst_b_i),
		.clk_en_i    (clk_en_i),
		.data_pin_i  (data_bus_i),
		.chain_pin_i (chain_enable_output_i), // RULE9
		.sy          (sy)
	);

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	// Counter gives each phase its least duration; the read phase waits the full
	// access time because the device answers combinationally with no ready line.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= CNT_ZERO;
			addr_q  <= '0;
		end
		else if (clk_en_i)
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (req_i)
					begin
						addr_q  <= req_addr_i;
						cnt_q   <= CNT_W'(SETUP_CYC);
						state_q <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					if (cnt_q == CNT_ONE)
					begin
						cnt_q   <= CNT_W'(STB_CYC);
						state_q <= ST_STB;
					end
					else
						cnt_q <= cnt_q - CNT_ONE;
				end
				ST_STB:
				begin
					if (cnt_q == CNT_ONE)
					begin
						cnt_q   <= CNT_ONE;
						state_q <= ST_LOW;
					end
					else
						cnt_q <= cnt_q - CNT_ONE;
				end
				ST_LOW:
				begin
					cnt_q   <= CNT_W'(ACC_CYC + 2);
					state_q <= ST_READ;
				end
				ST_READ:
				begin
					if (cnt_q == CNT_ONE)
						state_q <= ST_IDLE;
					else
						cnt_q <= cnt_q - CNT_ONE;
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Selects are driven active throughout the access with their mask sense
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			muxed_address_lines_o  <= '0;
			address_latch_strobe_o <= 1'b0;
			memory_read_enable_o   <= 1'b0;
			cs1_o                  <= ~CS1_ACTIVE_HIGH;
			cs2_o                  <= ~CS2_ACTIVE_HIGH;
		end
		else if (clk_en_i)
		begin
			case (state_q)
				ST_IDLE:
				begin
					memory_read_enable_o <= 1'b0;
					cs1_o                <= ~CS1_ACTIVE_HIGH;
					cs2_o                <= ~CS2_ACTIVE_HIGH;
					if (req_i)
						muxed_address_lines_o <= req_addr_i[HI_LSB +: BYTE_W]; // RULE1
				end
				ST_SETUP:
				begin
					cs1_o <= CS1_ACTIVE_HIGH; // RULE7
					cs2_o <= CS2_ACTIVE_HIGH; // RULE7
					if (cnt_q == CNT_ONE)
						address_latch_strobe_o <= 1'b1; // RULE1
				end
				ST_STB:
				begin
					if (cnt_q == CNT_ONE)
						address_latch_strobe_o <= 1'b0;
				end
				// Low byte waits a cycle after the strobe falls, so the latch never sees it change
				ST_LOW:
					muxed_address_lines_o <= addr_q[LO_LSB +: BYTE_W]; // RULE4
				// Read enable opens only once the low byte has settled
				ST_READ:
				begin
					if (cnt_q == CNT_ONE)
					begin
						memory_read_enable_o <= 1'b0;
						cs1_o                <= ~CS1_ACTIVE_HIGH;
						cs2_o                <= ~CS2_ACTIVE_HIGH;
					end
					else
						memory_read_enable_o <= 1'b1; // RULE6
				end
				default:
					address_latch_strobe_o <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Data bus and answer
	// ----------------------------------------------------------------
	// Host never drives the shared data lines during a read cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			data_bus_o    <= '0;
			data_bus_oe_o <= 1'b0;
			rsp_valid_o   <= 1'b0;
			rsp_data_o    <= '0;
			rsp_rom_o     <= 1'b0;
			busy_o        <= 1'b0;
		end
		else if (clk_en_i)
		begin
			data_bus_o    <= '0;
			data_bus_oe_o <= 1'b0; // RULE5
			rsp_valid_o   <= 1'b0;
			busy_o        <= (state_q != ST_IDLE) || req_i;
			if (state_q == ST_READ && cnt_q == CNT_ONE)
			begin
				rsp_valid_o <= 1'b1;
				rsp_data_o  <= sy.data; // RULE13
				rsp_rom_o   <= sy.chain; // RULE11
				busy_o      <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_strobe_hi_byte;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		address_latch_strobe_o |-> muxed_address_lines_o == addr_q[HI_LSB +: BYTE_W];
	endproperty
	a_strobe_hi_byte: assert property (p_strobe_hi_byte) else $error("strobe without high byte"); // RULE1

	property p_low_after_strobe;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$fell(address_latch_strobe_o) && clk_en_i |=> muxed_address_lines_o == addr_q[LO_LSB +: BYTE_W];
	endproperty
	a_low_after_strobe: assert property (p_low_after_strobe) else $error("low byte missing after strobe"); // RULE4

	property p_no_drive;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		memory_read_enable_o |-> !data_bus_oe_o;
	endproperty
	a_no_drive: assert property (p_no_drive) else $error("host drives bus during read"); // RULE5

	property p_read_selected;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		memory_read_enable_o |-> cs1_o == CS1_ACTIVE_HIGH && cs2_o == CS2_ACTIVE_HIGH;
	endproperty
	a_read_selected: assert property (p_read_selected) else $error("read without selects"); // RULE6

	property p_sel_sense;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> cs1_o == ~CS1_ACTIVE_HIGH;
	endproperty
	a_sel_sense: assert property (p_sel_sense) else $error("select active while idle"); // RULE7

	property p_rsp_timing;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(memory_read_enable_o) && clk_en_i |-> ##[1:300] rsp_valid_o;
	endproperty
	a_rsp_timing: assert property (p_rsp_timing) else $error("answer late"); // RULE13

	property p_strobe_width;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(address_latch_strobe_o) && clk_en_i |-> address_latch_strobe_o [*8];
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // RULE1

	property p_rsp_pulse;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		rsp_valid_o |=> !rsp_valid_o;
	endproperty
	a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer held"); // RULE11

	c_read: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) rsp_valid_o);
	c_rom_hit: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) rsp_valid_o && rsp_rom_o);
	c_ram_hit: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) rsp_valid_o && !rsp_rom_o);
endmodule : mrom_host

// ==== hw/mrom_pkg.sv ====
package mrom_pkg;
	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W      = 16;
	localparam int unsigned BYTE_W      = 8;
	localparam int unsigned HI_LSB      = 8;
	localparam int unsigned LO_LSB      = 0;
	// ----------------------------------------------------------------
	// Strobe timing: least widths, rounded up to cycles of 20 ns
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned STB_WIDTH_NS   = 300;
	localparam int unsigned ADDR_SETUP_NS  = 300;
	localparam int unsigned ACCESS_NS      = 1000;
	localparam int unsigned STB_CYC   = (STB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ACC_CYC   = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W     = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_STB   = 3'b010,
		ST_LOW   = 3'b011,
		ST_READ  = 3'b100
	} mrom_state_e;
endpackage : mrom_pkg

// ==== hw/mrom_sync_if.sv ====
`timescale 1ns/10ps
// Synchronised pin levels handed from the input stage to the sequencer
interface mrom_sync_if;
	logic [7:0] data;
	logic       chain;
	modport src (output data, output chain);
	modport dst (input data, input chain);
endinterface : mrom_sync_if

// ==== hw/mrom_sync.sv ====
`timescale 1ns/10ps
module mrom_sync
	import mrom_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              clk_en_i,
	input  wire logic [BYTE_W-1:0] data_pin_i,
	input  wire logic              chain_pin_i,
	mrom_sync_if.src               sy
);
	logic [BYTE_W:0] meta_q;
	logic [BYTE_W:0] stab_q;

	// ----------------------------------------------------------------
	// Two-stage synchroniser; first stage feeds only the second
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			meta_q <= '0;
			stab_q <= '0;
		end
		else if (clk_en_i)
		begin
			meta_q <= {chain_pin_i, data_pin_i};
			stab_q <= meta_q;
		end
	end

	assign sy.data  = stab_q[BYTE_W-1:0];
	assign sy.chain = stab_q[BYTE_W];
endmodule : mrom_sync

// ==== test/mrom_dev_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Mask ROM device with chain output, behavioural
// ----------------------------------------------------------------
module mrom_dev_model #(
	parameter logic [2:0] REGION   = 3'h0,
	parameter bit         CS1_HIGH = 1'b1,
	parameter bit         CS2_HIGH = 1'b1
)
(
	input  wire logic [7:0] muxed_address_lines_i,
	input  wire logic       address_latch_strobe_i,
	input  wire logic       memory_read_enable_i,
	input  wire logic       cs1_i,
	input  wire logic       cs2_i,
	input  wire logic       chain_enable_input_i,
	output logic            chain_enable_output_o,
	output logic [7:0]      data_o,
	output logic            data_oe_o
);
	// Starts in area 7, outside areas 0 and 1 used here, so neither device claims the bus before a strobe
	logic [7:0] hi_q = 8'hFF;
	logic       sel;
	// High byte held from the strobe's falling edge for the rest of the access
	always @(negedge address_latch_strobe_i) hi_q = muxed_address_lines_i;
	// Three latched bits pick the area; select levels are mask constants
	assign sel = (cs1_i == CS1_HIGH) && (cs2_i == CS2_HIGH) && (hi_q[6:4] == REGION);
	assign chain_enable_output_o = sel || chain_enable_input_i;
	// Outputs open only in a selected, enabled read
	assign data_oe_o = sel && memory_read_enable_i;
	// Latched nibble plus live low byte; content pattern is arbitrary
	assign data_o = muxed_address_lines_i ^ {hi_q[3:0], hi_q[3:0]} ^ {5'h00, REGION};
endmodule : mrom_dev_model

// ==== test/mrom_host_tb_top.sv ====
`timescale 1ns/10ps
module mrom_host_tb_top;
	import mrom_pkg::*;
	logic              clk;
	logic              rst_b;
	logic              clk_en;
	logic              req;
	logic [ADDR_W-1:0] req_addr;
	logic              busy, rsp_valid, rsp_rom, stb, rd, cs1, cs2, hb_oe, ch0, chain, oe0, oe1, chain_enable_input;
	logic [7:0]        rsp_data, lines, bus, hb_o, d0, d1, hi_seen, lo_seen;
	int                error_cnt  = 0;
	int                n_compared = 0;
	// ----------------------------------------------------------------
	// Design, two chained devices and the shared bus
	// ----------------------------------------------------------------
	mrom_host #(.CS1_ACTIVE_HIGH(1'b0)) uut (.ref_clk_i(clk), .rst_b_i(rst_b),
		.clk_en_i(clk_en), .req_i(req), .req_addr_i(req_addr), .busy_o(busy), .rsp_valid_o(rsp_valid),
		.rsp_data_o(rsp_data), .rsp_rom_o(rsp_rom), .muxed_address_lines_o(lines), .address_latch_strobe_o(stb),
		.memory_read_enable_o(rd), .cs1_o(cs1), .cs2_o(cs2), .data_bus_i(bus), .data_bus_o(hb_o),
		.data_bus_oe_o(hb_oe), .chain_enable_output_i(chain));
	// First device feeds the second; the last output is the RAM disable
	mrom_dev_model #(.CS1_HIGH(1'b0)) rom0 (.muxed_address_lines_i(lines),
		.address_latch_strobe_i(stb), .memory_read_enable_i(rd), .cs1_i(cs1), .cs2_i(cs2),
		.chain_enable_input_i(chain_enable_input), .chain_enable_output_o(ch0), .data_o(d0), .data_oe_o(oe0));
	mrom_dev_model #(.REGION(3'h1), .CS1_HIGH(1'b0)) rom1 (.muxed_address_lines_i(lines),
		.address_latch_strobe_i(stb), .memory_read_enable_i(rd), .cs1_i(cs1), .cs2_i(cs2),
		.chain_enable_input_i(ch0), .chain_enable_output_o(chain), .data_o(d1), .data_oe_o(oe1));
	// Undriven bus toggles on every clock edge so a stale byte never passes
	assign bus = oe0 ? d0 : (oe1 ? d1 : (hb_oe ? hb_o : {4{clk, ~clk}}));
	always @(negedge stb) hi_seen = lines;
	always @(posedge rd) lo_seen = lines;
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Compare tasks and closing
	// ----------------------------------------------------------------
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int got, input int exp);
		chk_val(got[15:0], exp[15:0]);
	endtask : chk_cnt
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// One read; a stray request mid-access, not sent when a stall jumps n past 20, must be ignored
	task automatic do_read(input logic [15:0] a, input int stall, input logic rom);
		int n;
		req_addr = a;
		req      = 1'b1;
		@(posedge clk);
		#1 req = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 300)
		begin
			@(posedge clk);
			#1 n++;
			if (n == 10 && stall > 0)
			begin
				clk_en = 1'b0;
				repeat (stall) @(posedge clk);
				#1 clk_en = 1'b1;
				n += stall;
			end
			if (n == 20)
			begin
				req      = 1'b1;
				req_addr = ~a;
			end
			if (n == 21)
				req = 1'b0;
			if (n == 40)
				chk_val({busy, cs1, cs2}, 3'b101);
		end
		chk_cnt(n, int'(SETUP_CYC + STB_CYC + 1 + ACC_CYC + 2) + stall);
		chk_val(hi_seen, a[15:8]);
		chk_val(lo_seen, a[7:0]);
		chk_val(rsp_rom, rom);
		if (rom && !chain_enable_input)
			chk_val(rsp_data, a[7:0] ^ {a[11:8], a[11:8]} ^ {5'h00, a[14:12]});
		chk_val({oe0, oe1, chain, busy}, {2'b00, chain_enable_input, 1'b0});
	endtask : do_read
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk_val({stb, rd, cs1, cs2, busy, rsp_valid, lines}, {6'b001000, 8'h00});
		$display("t_reset done");
	endtask : t_reset
	task automatic t_rom();
		logic [15:0] tbl [5] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h1ABC, 16'h1FFF};
		foreach (tbl[i]) do_read(tbl[i], 0, 1'b1);
		$display("t_rom done");
	endtask : t_rom
	task automatic t_ram();
		logic [15:0] tbl [3] = '{16'h2000, 16'h7F5A, 16'hE123};
		foreach (tbl[i]) do_read(tbl[i], 0, 1'b0);
		$display("t_ram done");
	endtask : t_ram
	// Chain input high claims a RAM address for the chain without any device driving
	task automatic t_chain();
		chain_enable_input = 1'b1;
		do_read(16'h2000, 0, 1'b1);
		chain_enable_input = 1'b0;
		$display("t_chain done");
	endtask : t_chain
	task automatic t_freeze();
		do_read(16'h1357, 20, 1'b1);
		$display("t_freeze done");
	endtask : t_freeze
	initial
	begin
		rst_b    = 1'b0;
		clk_en   = 1'b1;
		chain_enable_input      = 1'b0;
		req      = 1'b0;
		req_addr = 16'h0000;
		repeat (16) @(posedge clk);
		#1 t_reset();
		rst_b = 1'b1;
		t_rom();
		t_ram();
		t_chain();
		t_freeze();
		end_of_test();
	end
	// Whole run needs about 880 cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end
endmodule : mrom_host_tb_top
